// *** pkg/hpog_pkg.sv ***
// Constants, modes and state types for the host port oscillator gating block
package hpog_pkg;

	// Register byte offsets
	localparam logic [7:0] HPOG_CTRL_OFS = 8'h10;
	localparam logic [7:0] HPOG_ACT_OFS = 8'h14;
	localparam logic [7:0] HPOG_STAT_OFS = 8'h18;

	// Control register fields
	localparam int HPOG_POL_LSB = 0;
	localparam int HPOG_THRU_BIT = 2;
	localparam int HPOG_ACT_BIT = 0;

	// Status register fields
	localparam int HPOG_ST_PERMIT_BIT = 0;
	localparam int HPOG_ST_CRSTOP_BIT = 1;
	localparam int HPOG_ST_PD_BIT = 2;
	localparam int HPOG_ST_TXN_BIT = 3;

	// Values after reset
	localparam logic [1:0] HPOG_POL_RST = 2'h0;
	localparam logic HPOG_THRU_RST = 1'b1;
	localparam logic HPOG_ACT_RST = 1'b0;
	localparam logic HPOG_PERMIT_RST = 1'b1;
	// Synchroniser level after reset, order {power_down_n, clkrun_n, host_bus_clock}
	localparam logic [2:0] HPOG_SYNC_RST = 3'h4;

	// Host bus clock edges with the run line high that signal a clock stop
	localparam logic [2:0] HPOG_CLKRUN_STOP_CYC = 3'h5;

	// AXI responses
	localparam logic [1:0] HPOG_RESP_OKAY = 2'h0;
	localparam logic [1:0] HPOG_RESP_SLVERR = 2'h2;

	// Gating policies, in field order 0..3
	typedef enum logic [1:0] {
		HPOG_POL_POWER_DOWN,
		HPOG_POL_CLKRUN,
		HPOG_POL_PER_TXN,
		HPOG_POL_NEVER
	} hpog_pol_e;

	// Pin synchroniser state
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] lvl;
		logic rise;
	} hpog_sync_s;

	// Gating and register state
	typedef struct packed {
		hpog_pol_e pol;
		logic thru;
		logic act;
		logic clkrun_hb;
		logic pd_n_hb;
		logic [2:0] cr_cnt;
		logic cr_stop;
		logic txn_flag;
		logic permit;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} hpog_st_s;

endpackage : hpog_pkg

// *** pkg/hpog_pin_if.sv ***
// Synchronised host pin levels passed from the pin stage to the gating logic
`timescale 1ns/1ns
interface hpog_pin_if;
	logic host_clk_rise;
	logic clkrun_n_lvl;
	logic power_down_n_lvl;

	modport src (
		output host_clk_rise,
		output clkrun_n_lvl,
		output power_down_n_lvl
	);

	modport dst (
		input host_clk_rise,
		input clkrun_n_lvl,
		input power_down_n_lvl
	);
endinterface : hpog_pin_if

// *** design/hpog_pin_sync.sv ***
// Three-stage synchronisers and host bus clock edge finder for the host pins
`timescale 1ns/1ns
module hpog_pin_sync import hpog_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Host pins
	input wire logic host_bus_clock,
	input wire logic clkrun_n,
	input wire logic power_down_n,
	// Synchronised levels
	hpog_pin_if.src pins
);

	hpog_sync_s st;
	hpog_sync_s next_st;

	// Filtered level moves only when stages two and three agree
	always_comb begin
		next_st = st;
		next_st.s1 = {power_down_n, clkrun_n, host_bus_clock};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 3; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.lvl[i] = st.s3[i];
			end
		end
		next_st.rise = next_st.lvl[0] & ~st.lvl[0];
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '{s1: HPOG_SYNC_RST, s2: HPOG_SYNC_RST, s3: HPOG_SYNC_RST, lvl: HPOG_SYNC_RST, rise: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign pins.host_clk_rise = st.rise;
	assign pins.clkrun_n_lvl = st.lvl[1];
	assign pins.power_down_n_lvl = st.lvl[2];

endmodule : hpog_pin_sync

// *** design/hpog_top.sv ***
// Host port oscillator gating policy with its AXI4-Lite register slave
//
// Behaviour
// - Throughput bit selects clock range, resets one
// - Policy 0: stop allowed while power-down asserted
// - Policy 1: clock-stop signalled and nothing pending
// - Clock-stop: run line high five host clocks
// - Policy 2: stop allowed after a completed transaction while interface not busy
// - Policy 3: never stop while interface active
// - Inactive interface: stop allowed, policy ignored
// - Only permits stopping; never restarts the oscillator
// - Policy field two bits, writable, resets zero
`timescale 1ns/1ns
module hpog_top import hpog_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Host pins
	input wire logic host_bus_clock,
	input wire logic clkrun_n,
	input wire logic power_down_n,
	// Host interface activity, same clock
	input wire logic serirq_pending,
	input wire logic dma_pending,
	input wire logic txn_start,
	input wire logic txn_done,
	input wire logic host_if_busy,
	// Oscillator control
	output logic osc_stop_permit,
	output logic wide_clock_range,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);

	hpog_pin_if pins ();
	hpog_st_s st;
	hpog_st_s next_st;
	logic permit_now;

	// Pin synchronisers
	hpog_pin_sync u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.host_bus_clock(host_bus_clock),
		.clkrun_n(clkrun_n),
		.power_down_n(power_down_n),
		.pins(pins)
	);

	// Address is one of the mapped words
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == HPOG_CTRL_OFS) || (a == HPOG_ACT_OFS) || (a == HPOG_STAT_OFS);
	endfunction : addr_mapped

	// Read view of a register word, zero for reserved bits
	function automatic logic [31:0] reg_word(input logic [7:0] a, input hpog_st_s s);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			HPOG_CTRL_OFS: begin
				w[HPOG_POL_LSB +: 2] = s.pol;
				w[HPOG_THRU_BIT] = s.thru;
			end
			HPOG_ACT_OFS: begin
				w[HPOG_ACT_BIT] = s.act;
			end
			HPOG_STAT_OFS: begin
				w[HPOG_ST_PERMIT_BIT] = s.permit;
				w[HPOG_ST_CRSTOP_BIT] = s.cr_stop;
				w[HPOG_ST_PD_BIT] = ~s.pd_n_hb;
				w[HPOG_ST_TXN_BIT] = s.txn_flag;
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction : reg_word

	// Gating decision from current state; no restart output exists at all
	always_comb begin
		permit_now = 1'b1;
		if (st.act) begin
			case (st.pol)
				HPOG_POL_POWER_DOWN: permit_now = ~st.pd_n_hb;
				HPOG_POL_CLKRUN: permit_now = st.cr_stop & ~serirq_pending & ~dma_pending;
				HPOG_POL_PER_TXN: permit_now = st.txn_flag & ~host_if_busy;
				HPOG_POL_NEVER: permit_now = 1'b0;
				default: permit_now = 1'b0;
			endcase
		end // Inactive interface leaves permit high
	end

	// Next state of the whole block
	always_comb begin
		next_st = st;
		next_st.permit = permit_now;

		// Sample levels on host clock edges
		if (pins.host_clk_rise) begin
			next_st.clkrun_hb = pins.clkrun_n_lvl;
			next_st.pd_n_hb = pins.power_down_n_lvl;
			// Count host clocks with the run line high
			if (pins.clkrun_n_lvl) begin
				if (st.cr_cnt != HPOG_CLKRUN_STOP_CYC) begin
					next_st.cr_cnt = st.cr_cnt + 3'h1;
				end
			end else begin
				next_st.cr_cnt = 3'h0;
			end
			next_st.cr_stop = pins.clkrun_n_lvl && (next_st.cr_cnt == HPOG_CLKRUN_STOP_CYC);
		end

		// Completed transaction flag; a completion beats a start in one cycle
		if (txn_done) begin
			next_st.txn_flag = 1'b1;
		end else if (txn_start) begin
			next_st.txn_flag = 1'b0;
		end

		// Write channels are taken independently
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end

		// Commit once both halves are held and no response waits
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = addr_mapped(st.awaddr) ? HPOG_RESP_OKAY : HPOG_RESP_SLVERR;
			if (st.wstrb[0]) begin
				if (st.awaddr == HPOG_CTRL_OFS) begin
					next_st.pol = hpog_pol_e'(st.wdata[HPOG_POL_LSB +: 2]);
					next_st.thru = st.wdata[HPOG_THRU_BIT];
				end
				// Clearing activate is allowed here; keeping off it is the host's duty
				if (st.awaddr == HPOG_ACT_OFS) begin
					next_st.act = st.wdata[HPOG_ACT_BIT];
				end
			end
		end else if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// Reads answer one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = reg_word(s_axi_araddr, st);
			next_st.rresp = addr_mapped(s_axi_araddr) ? HPOG_RESP_OKAY : HPOG_RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.pol <= hpog_pol_e'(HPOG_POL_RST);
			st.thru <= HPOG_THRU_RST;
			st.act <= HPOG_ACT_RST;
			st.pd_n_hb <= 1'b1;
			st.permit <= HPOG_PERMIT_RST;
		end else begin
			st <= next_st;
		end
	end

	// Write readies invert held flags, read ready inverts rvalid; valids and payloads come from flip-flops
	assign s_axi_awready = ~st.aw_held;
	assign s_axi_wready = ~st.w_held;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign osc_stop_permit = st.permit;
	assign wide_clock_range = st.thru;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Inactive interface always permits, whatever the policy
	property p_inactive_permits;
		!st.act |=> osc_stop_permit;
	endproperty
	a_inactive_permits: assert property (p_inactive_permits) else $error("Inactive interface did not permit stop");

	// Power-down policy follows the sampled power-down line
	property p_power_down_policy;
		(st.act && st.pol == HPOG_POL_POWER_DOWN) |=> (osc_stop_permit == !$past(st.pd_n_hb));
	endproperty
	a_power_down_policy: assert property (p_power_down_policy) else $error("Power-down policy permit wrong");

	// Pending requests forbid the stop under the run-line policy
	sequence s_clkrun_busy;
		st.act && st.pol == HPOG_POL_CLKRUN && (serirq_pending || dma_pending || !st.cr_stop);
	endsequence
	property p_clkrun_policy;
		s_clkrun_busy |=> !osc_stop_permit;
	endproperty
	a_clkrun_policy: assert property (p_clkrun_policy) else $error("Run-line policy permitted while busy");

	// A low run-line sample clears the stop indication
	sequence s_clkrun_low;
		pins.host_clk_rise && !pins.clkrun_n_lvl;
	endsequence
	property p_clkrun_count;
		(s_clkrun_low |=> !st.cr_stop && st.cr_cnt == 3'h0) and (st.cr_stop |-> st.cr_cnt == HPOG_CLKRUN_STOP_CYC);
	endproperty
	a_clkrun_count: assert property (p_clkrun_count) else $error("Run-line stop count wrong");

	// Completion then an idle interface yields a permit
	sequence s_txn_complete;
		st.act && st.pol == HPOG_POL_PER_TXN && txn_done ##1 (!host_if_busy && !txn_start && st.act && st.pol == HPOG_POL_PER_TXN);
	endsequence
	property p_txn_policy;
		s_txn_complete |=> osc_stop_permit;
	endproperty
	a_txn_policy: assert property (p_txn_policy) else $error("Per-transaction policy did not permit");

	// Never-stop policy keeps permit low
	property p_never_policy;
		(st.act && st.pol == HPOG_POL_NEVER) [*2] |-> !osc_stop_permit;
	endproperty
	a_never_policy: assert property (p_never_policy) else $error("Never-stop policy permitted");

	// Control write lands in both fields when the response rises
	sequence s_ctrl_write;
		$rose(st.bvalid) && st.awaddr == HPOG_CTRL_OFS && st.wstrb[0];
	endsequence
	property p_ctrl_write;
		s_ctrl_write |-> (wide_clock_range == st.wdata[HPOG_THRU_BIT]) && (st.pol == st.wdata[HPOG_POL_LSB +: 2]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("Control write not stored");

	// Policy field only changes through a control write
	property p_pol_stable;
		!$stable(st.pol) |-> $rose(st.bvalid) && st.awaddr == HPOG_CTRL_OFS;
	endproperty
	a_pol_stable: assert property (p_pol_stable) else $error("Policy field changed without a write");

	// Host-clock samples take the synchronised levels
	property p_sync_sample;
		pins.host_clk_rise |=> st.clkrun_hb == $past(pins.clkrun_n_lvl) && st.pd_n_hb == $past(pins.power_down_n_lvl);
	endproperty
	a_sync_sample: assert property (p_sync_sample) else $error("Host-clock sample mismatch");

	// Stop indication rises only from one short of the limit, never early
	property p_clkrun_rise;
		$rose(st.cr_stop) |-> $past(st.cr_cnt) == HPOG_CLKRUN_STOP_CYC - 3'h1;
	endproperty
	a_clkrun_rise: assert property (p_clkrun_rise) else $error("Run-line stop raised too early");

	// Stop seen with nothing pending must permit
	sequence s_clkrun_idle;
		st.act && st.pol == HPOG_POL_CLKRUN && st.cr_stop && !serirq_pending && !dma_pending;
	endsequence
	property p_clkrun_permit;
		s_clkrun_idle |=> osc_stop_permit;
	endproperty
	a_clkrun_permit: assert property (p_clkrun_permit) else $error("Run-line policy did not permit");

	// Busy interface or no completion forbids the stop
	property p_txn_blocked;
		(st.act && st.pol == HPOG_POL_PER_TXN && (host_if_busy || !st.txn_flag)) |=> !osc_stop_permit;
	endproperty
	a_txn_blocked: assert property (p_txn_blocked) else $error("Per-transaction policy permitted early");

	// Power-down sample moves only on a host clock rise
	property p_pd_sample_edge;
		!$stable(st.pd_n_hb) |-> $past(pins.host_clk_rise);
	endproperty
	a_pd_sample_edge: assert property (p_pd_sample_edge) else $error("Power-down sample moved off edge");

	// Run-line count moves only on a host clock rise
	property p_cr_cnt_edge;
		!$stable(st.cr_cnt) |-> $past(pins.host_clk_rise);
	endproperty
	a_cr_cnt_edge: assert property (p_cr_cnt_edge) else $error("Run-line count moved off edge");

endmodule : hpog_top

// *** verification/hpog_host_model.sv ***
// Behavioural host chipset driving the host bus clock, run line and power-down pin
`timescale 1ns/1ns
module hpog_host_model (
	// Requests from the bench
	input wire logic stop_req,
	input wire logic pd_req,
	// Host pins
	output logic host_bus_clock,
	output logic clkrun_n,
	output logic power_down_n
);
	// Free-running 400 ns bus clock, unrelated in phase to ref_clk
	initial begin
		host_bus_clock = 1'b0;
		#137;
		forever #200 host_bus_clock = ~host_bus_clock;
	end
	// Run line moves on the falling edge so it is stable at each rise
	initial clkrun_n = 1'b0;
	always @(negedge host_bus_clock) clkrun_n <= stop_req;
	// Level pin; this host never clears activate over the bus
	assign power_down_n = ~pd_req;
endmodule : hpog_host_model

// *** verification/host_port_oscillator_gating_tb.sv ***
// Self-checking bench for the host port oscillator gating block
`timescale 1ns/1ns
module host_port_oscillator_gating_tb;
	import hpog_pkg::*;
	logic ref_clk, rst, stop_req, pd_req, serirq_pending, dma_pending, txn_start, txn_done, host_if_busy;
	logic host_bus_clock, clkrun_n, power_down_n, osc_stop_permit, wide_clock_range;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_total, n_checks;

	hpog_top i_dut (.ref_clk, .rst, .host_bus_clock, .clkrun_n, .power_down_n, .serirq_pending,
		.dma_pending, .txn_start, .txn_done, .host_if_busy, .osc_stop_permit, .wide_clock_range,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	hpog_host_model i_host (.stop_req, .pd_req, .host_bus_clock, .clkrun_n, .power_down_n);

	// 20 MHz system clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Write with address and data offered together, each released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		int n;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(!aw && !w && s_axi_bvalid === 1'b1) && n < 40);
		s_axi_bready <= 1'b0;
		chk("bresp", {1'b1, er}, {s_axi_bvalid, s_axi_bresp});
		// One edge apart, so a next call never reassigns in this time step
		@(posedge ref_clk);
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		s_axi_rready <= 1'b0;
		chk("rresp", {1'b1, er}, {s_axi_rvalid, s_axi_rresp});
		chk("rdata", ed, s_axi_rdata);
		// One edge apart, so a next call never reassigns in this time step
		@(posedge ref_clk);
	endtask : axr

	// Bounded wait, since the pins pass through synchronisers first
	task automatic wp(input logic e, input int lim);
		int n;
		n = 0;
		while (osc_stop_permit !== e && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		chk("permit", e, osc_stop_permit);
	endtask : wp

	task automatic t_reset;
		axr(HPOG_CTRL_OFS, 32'h4, HPOG_RESP_OKAY);
		axr(HPOG_ACT_OFS, 32'h0, HPOG_RESP_OKAY);
		chk("wide", 1, wide_clock_range);
		chk("permit", 1, osc_stop_permit);
		axr(8'h1C, 32'h0, HPOG_RESP_SLVERR);
		axw(8'h1C, 32'hFFFFFFFF, HPOG_RESP_SLVERR);
		$display("test reset done");
	endtask : t_reset

	task automatic t_pd;
		axw(HPOG_ACT_OFS, 32'h1, HPOG_RESP_OKAY);
		wp(0, 20);
		pd_req <= 1'b1;
		wp(1, 20);
		pd_req <= 1'b0;
		wp(0, 20);
		$display("test power down done");
	endtask : t_pd

	task automatic t_crun;
		axw(HPOG_CTRL_OFS, 32'h5, HPOG_RESP_OKAY);
		stop_req <= 1'b1;
		// Count rises only once the pin is high
		wait (clkrun_n === 1'b1);
		repeat (4) @(posedge host_bus_clock);
		@(posedge ref_clk);
		chk("permit", 0, osc_stop_permit);
		// Fifth rise: permit within the sync lag, well before a sixth rise
		@(posedge host_bus_clock);
		wp(1, 8);
		axr(HPOG_STAT_OFS, 32'h3, HPOG_RESP_OKAY);
		dma_pending <= 1'b1;
		wp(0, 10);
		dma_pending <= 1'b0;
		wp(1, 10);
		serirq_pending <= 1'b1;
		wp(0, 10);
		serirq_pending <= 1'b0;
		wp(1, 10);
		stop_req <= 1'b0;
		wp(0, 200);
		$display("test clock run done");
	endtask : t_crun

	task automatic t_txn;
		axw(HPOG_CTRL_OFS, 32'h6, HPOG_RESP_OKAY);
		wp(0, 10);
		txn_done <= 1'b1;
		@(posedge ref_clk);
		txn_done <= 1'b0;
		wp(1, 10);
		host_if_busy <= 1'b1;
		wp(0, 10);
		host_if_busy <= 1'b0;
		wp(1, 10);
		txn_start <= 1'b1;
		@(posedge ref_clk);
		txn_start <= 1'b0;
		wp(0, 10);
		$display("test transaction done");
	endtask : t_txn

	task automatic t_never;
		axw(HPOG_CTRL_OFS, 32'h3, HPOG_RESP_OKAY);
		chk("wide", 0, wide_clock_range);
		axr(HPOG_CTRL_OFS, 32'h3, HPOG_RESP_OKAY);
		pd_req <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk("permit", 0, osc_stop_permit);
		axw(HPOG_ACT_OFS, 32'h0, HPOG_RESP_OKAY);
		wp(1, 10);
		$display("test never done");
	endtask : t_never

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// Watchdog well beyond the expected run
	initial begin
		#1000000;
		err_total++;
		stop_test();
	end

	// Main sequence
	initial begin
		{rst, stop_req, pd_req, serirq_pending, dma_pending, txn_start, txn_done, host_if_busy} = 8'h80;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		err_total = 0;
		n_checks = 0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_pd();
		t_crun();
		t_txn();
		t_never();
		stop_test();
	end
endmodule : host_port_oscillator_gating_tb
